// [verilog/tpec_error_counters.sv]
// Receive path error counters: path violations, sync errors, E-bits.
// Assumes framer strobes and sync levels are synchronous to mclk.
`timescale 1ns/1ps
module tpec_error_counters #(
  parameter logic [12:0] SEC_FRAMES = tpec_pkg::ONE_SEC_FRAMES
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire tpec_pkg::tpec_cfg_type cfg,
  input wire tpec_pkg::tpec_sync_type sync,
  input wire tpec_pkg::tpec_evt_type evt,
  input wire logic rd_en,
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data,
  output logic update_pulse
);

  typedef struct packed {
    logic [tpec_pkg::NUM_CNT-1:0][15:0] cnt;
    logic [tpec_pkg::NUM_CNT-1:0][15:0] latched;
    logic trig_prev;
    logic [7:0] rd_data;
  } tpec_state_type;

  tpec_state_type st_reg;
  tpec_state_type st_next;
  logic timer_tick;
  logic manual_rise;
  logic upd;
  logic t1_mode;
  logic e1_synced;
  logic e1_searching;
  logic pv_inc;
  logic sync_inc;
  logic febe_inc;
  logic [tpec_pkg::NUM_CNT-1:0] inc;

  tpec_interval_timer #(
    .SEC_FRAMES(SEC_FRAMES)
  ) u_timer (
    .mclk(mclk),
    .nrst(nrst),
    .frame_pulse(evt.frame_pulse),
    .e1_mode(cfg.e1_mode),
    .short_interval_select(cfg.short_interval_select),
    .tick(timer_tick)
  );

  assign t1_mode = !cfg.e1_mode;
  // CAS multiframe loss alone does not stop the path or E-bit counts
  assign e1_synced = !sync.fas_lost && !sync.crc4_mf_lost;
  assign e1_searching = sync.fas_lost || sync.crc4_mf_lost
                        || sync.cas_mf_lost;

  // Update source: manual edge or interval timer, never both
  assign manual_rise = cfg.manual_update_trigger && !st_reg.trig_prev;
  assign upd = cfg.accumulation_mode_select ? manual_rise
                                            : timer_tick;

  always_comb begin
    pv_inc = 1'b0;
    if (t1_mode) begin
      if (!sync.receive_sync_lost_flag) begin
        if (cfg.t1_framing_mode_select) begin
          pv_inc = evt.crc6_err;
        end else begin
          pv_inc = evt.ft_err
                   || (cfg.fs_error_report_enable && evt.fs_err);
        end
      end
    end else begin
      pv_inc = evt.crc4_err && e1_synced;
    end
  end

  always_comb begin
    sync_inc = 1'b0;
    if (t1_mode) begin
      if (cfg.mos_or_fbit_select) begin
        // Multiframe counting ignores the sync-lost flag
        sync_inc = evt.mf_out_of_sync;
      end else if (!sync.receive_sync_lost_flag) begin
        sync_inc = cfg.t1_framing_mode_select ? evt.fps_err
                                              : evt.ft_err;
      end
    end else begin
      sync_inc = evt.fas_word_err && !sync.receive_sync_lost_flag
                 && !e1_searching;
    end
  end

  // E-bit strobe marks the first bit of frames 13 and 15
  assign febe_inc = cfg.e1_mode
                    && sync.crc4_mf_active && evt.ebit_strobe
                    && !evt.ebit_value
                    && e1_synced;

  always_comb begin
    inc = '0;
    inc[tpec_pkg::PV_IDX] = pv_inc;
    inc[tpec_pkg::SYNC_IDX] = sync_inc;
    inc[tpec_pkg::FEBE_IDX] = febe_inc;
  end

  always_comb begin
    st_next = st_reg;
    st_next.trig_prev = cfg.manual_update_trigger;
    for (int i = 0; i < tpec_pkg::NUM_CNT; i++) begin
      if (upd) begin
        // Event in the update cycle opens the new interval
        st_next.latched[i] = st_reg.cnt[i];
        st_next.cnt[i] = inc[i] ? tpec_pkg::CNT_ONE
                                : tpec_pkg::CNT_RESET;
      end else if (inc[i] && st_reg.cnt[i] != tpec_pkg::CNT_MAX) begin
        st_next.cnt[i] = st_reg.cnt[i] + tpec_pkg::CNT_ONE;
      end
    end
    if (rd_en) begin
      unique case (rd_addr)
        tpec_pkg::PV_HIGH_ADDR:
          st_next.rd_data =
            st_reg.latched[tpec_pkg::PV_IDX][15:8];
        tpec_pkg::PV_LOW_ADDR:
          st_next.rd_data =
            st_reg.latched[tpec_pkg::PV_IDX][7:0];
        tpec_pkg::SYNC_HIGH_ADDR:
          st_next.rd_data =
            st_reg.latched[tpec_pkg::SYNC_IDX][15:8];
        tpec_pkg::SYNC_LOW_ADDR:
          st_next.rd_data =
            st_reg.latched[tpec_pkg::SYNC_IDX][7:0];
        tpec_pkg::FEBE_HIGH_ADDR:
          st_next.rd_data =
            st_reg.latched[tpec_pkg::FEBE_IDX][15:8];
        tpec_pkg::FEBE_LOW_ADDR:
          st_next.rd_data =
            st_reg.latched[tpec_pkg::FEBE_IDX][7:0];
        default:
          st_next.rd_data = tpec_pkg::RD_RESET;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rd_data = st_reg.rd_data;
  assign update_pulse = upd;

  // Helper views for the checks below
  logic [15:0] pv_cnt;
  logic [15:0] sync_cnt;
  logic [15:0] febe_cnt;
  assign pv_cnt = st_reg.cnt[tpec_pkg::PV_IDX];
  assign sync_cnt = st_reg.cnt[tpec_pkg::SYNC_IDX];
  assign febe_cnt = st_reg.cnt[tpec_pkg::FEBE_IDX];

  property p_crc6_count;
    @(posedge mclk) disable iff (!nrst)
    (t1_mode && cfg.t1_framing_mode_select && evt.crc6_err
     && !sync.receive_sync_lost_flag && !upd && pv_cnt != 16'hFFFF)
    |=> pv_cnt == $past(pv_cnt) + 16'h0001;
  endproperty
  a_crc6_count:
    assert property (p_crc6_count) else $error("CRC6 error not counted");

  property p_fs_gate;
    @(posedge mclk) disable iff (!nrst)
    (t1_mode && !cfg.t1_framing_mode_select && evt.fs_err && !evt.ft_err
     && !sync.receive_sync_lost_flag && !upd && pv_cnt != 16'hFFFF)
    |=> pv_cnt == $past(pv_cnt)
                  + {15'h0000, $past(cfg.fs_error_report_enable)};
  endproperty
  a_fs_gate:
    assert property (p_fs_gate) else $error("Fs error gating wrong");

  property p_t1_pv_hold;
    @(posedge mclk) disable iff (!nrst)
    (t1_mode && sync.receive_sync_lost_flag && !upd)
    |=> pv_cnt == $past(pv_cnt);
  endproperty
  a_t1_pv_hold:
    assert property (p_t1_pv_hold) else $error("Path count moved, sync lost");

  property p_crc4_count;
    @(posedge mclk) disable iff (!nrst)
    (cfg.e1_mode && evt.crc4_err && !sync.fas_lost && !sync.crc4_mf_lost
     && !upd && pv_cnt != 16'hFFFF)
    |=> pv_cnt == $past(pv_cnt) + 16'h0001;
  endproperty
  a_crc4_count:
    assert property (p_crc4_count) else $error("CRC-4 error not counted");

  property p_e1_pv_hold;
    @(posedge mclk) disable iff (!nrst)
    (cfg.e1_mode && (sync.fas_lost || sync.crc4_mf_lost) && !upd)
    |=> pv_cnt == $past(pv_cnt) && febe_cnt == $past(febe_cnt);
  endproperty
  a_e1_pv_hold:
    assert property (p_e1_pv_hold) else $error("E1 count moved out of sync");

  property p_pv_read;
    @(posedge mclk) disable iff (!nrst)
    (rd_en && rd_addr == 8'h44)
    |=> rd_data == $past(st_reg.latched[0][15:8]);
  endproperty
  a_pv_read:
    assert property (p_pv_read) else $error("Path high byte read wrong");

  property p_mos_count;
    @(posedge mclk) disable iff (!nrst)
    (t1_mode && cfg.mos_or_fbit_select && evt.mf_out_of_sync
     && !upd && sync_cnt != 16'hFFFF)
    |=> sync_cnt == $past(sync_cnt) + 16'h0001;
  endproperty
  a_mos_count:
    assert property (p_mos_count) else $error("Out-of-sync mf not counted");

  property p_fbit_hold;
    @(posedge mclk) disable iff (!nrst)
    (t1_mode && !cfg.mos_or_fbit_select
     && sync.receive_sync_lost_flag && !upd)
    |=> sync_cnt == $past(sync_cnt);
  endproperty
  a_fbit_hold:
    assert property (p_fbit_hold) else $error("F-bit count moved, sync lost");

  property p_fas_count;
    @(posedge mclk) disable iff (!nrst)
    (cfg.e1_mode && evt.fas_word_err && !sync.receive_sync_lost_flag
     && !e1_searching && !upd && sync_cnt != 16'hFFFF)
    |=> sync_cnt == $past(sync_cnt) + 16'h0001;
  endproperty
  a_fas_count:
    assert property (p_fas_count) else $error("FAS word error not counted");

  property p_fas_search_hold;
    @(posedge mclk) disable iff (!nrst)
    (cfg.e1_mode && sync.cas_mf_lost && !upd)
    |=> sync_cnt == $past(sync_cnt);
  endproperty
  a_fas_search_hold:
    assert property (p_fas_search_hold) else $error("FAS counted in search");

  property p_febe_t1_off;
    @(posedge mclk) disable iff (!nrst)
    (t1_mode && !upd) |=> febe_cnt == $past(febe_cnt);
  endproperty
  a_febe_t1_off:
    assert property (p_febe_t1_off) else $error("E-bit count moved in T1");

  property p_febe_count;
    @(posedge mclk) disable iff (!nrst)
    (cfg.e1_mode && sync.crc4_mf_active && evt.ebit_strobe
     && !evt.ebit_value && sync.cas_mf_lost && !sync.fas_lost
     && !sync.crc4_mf_lost && !upd && febe_cnt != 16'hFFFF)
    |=> febe_cnt == $past(febe_cnt) + 16'h0001;
  endproperty
  a_febe_count:
    assert property (p_febe_count) else $error("Zero E-bit not counted");

  property p_saturate;
    @(posedge mclk) disable iff (!nrst)
    (pv_cnt == 16'hFFFF && !upd) |=> pv_cnt == 16'hFFFF;
  endproperty
  a_saturate:
    assert property (p_saturate) else $error("Path count wrapped");

  property p_manual_latch;
    @(posedge mclk) disable iff (!nrst)
    (cfg.accumulation_mode_select && cfg.manual_update_trigger
     && !st_reg.trig_prev)
    |=> st_reg.latched[2] == $past(febe_cnt) && febe_cnt <= 16'h0001;
  endproperty
  a_manual_latch:
    assert property (p_manual_latch) else $error("Manual update missed");

  property p_auto_only;
    @(posedge mclk) disable iff (!nrst)
    (!cfg.accumulation_mode_select && !timer_tick)
    |=> st_reg.latched == $past(st_reg.latched);
  endproperty
  a_auto_only:
    assert property (p_auto_only) else $error("Latched counts moved early");

  property p_feb_read;
    @(posedge mclk) disable iff (!nrst)
    (rd_en && rd_addr == 8'h49)
    |=> rd_data == $past(st_reg.latched[2][7:0]);
  endproperty
  a_feb_read:
    assert property (p_feb_read) else $error("E-bit low byte read wrong");

  property p_sync_read;
    @(posedge mclk) disable iff (!nrst)
    (rd_en && rd_addr == tpec_pkg::SYNC_LOW_ADDR)
    |=> rd_data == $past(st_reg.latched[tpec_pkg::SYNC_IDX][7:0]);
  endproperty
  a_sync_read:
    assert property (p_sync_read)
      else $error("Sync low byte read wrong");

  property p_unmapped_read;
    @(posedge mclk) disable iff (!nrst)
    (rd_en && (rd_addr < tpec_pkg::PV_HIGH_ADDR
               || rd_addr > tpec_pkg::FEBE_LOW_ADDR))
    |=> rd_data == tpec_pkg::RD_RESET;
  endproperty
  a_unmapped_read:
    assert property (p_unmapped_read)
      else $error("Unmapped read not zero");

  property p_fas_align_hold;
    @(posedge mclk) disable iff (!nrst)
    (cfg.e1_mode && (sync.fas_lost || sync.crc4_mf_lost) && !upd)
    |=> sync_cnt == $past(sync_cnt);
  endproperty
  a_fas_align_hold:
    assert property (p_fas_align_hold)
      else $error("FAS counted while aligning");

endmodule

// [inc/tpec_pkg.sv]
// Constants and carrier types for the receive path error counters.
// Assumes one 40 MHz clock; framer events arrive as one-cycle strobes.
package tpec_pkg;

  // Byte offsets of the count registers, high byte first
  localparam logic [7:0] PV_HIGH_ADDR = 8'h44;
  localparam logic [7:0] PV_LOW_ADDR = 8'h45;
  localparam logic [7:0] SYNC_HIGH_ADDR = 8'h46;
  localparam logic [7:0] SYNC_LOW_ADDR = 8'h47;
  localparam logic [7:0] FEBE_HIGH_ADDR = 8'h48;
  localparam logic [7:0] FEBE_LOW_ADDR = 8'h49;

  // Counter slots
  localparam int NUM_CNT = 3;
  localparam int PV_IDX = 0;
  localparam int SYNC_IDX = 1;
  localparam int FEBE_IDX = 2;

  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [7:0] RD_RESET = 8'h00;

  // Update intervals in received frames
  localparam logic [12:0] T1_SHORT_FRAMES = 13'd333;
  localparam logic [12:0] E1_SHORT_FRAMES = 13'd500;
  localparam logic [12:0] ONE_SEC_FRAMES = 13'd8000;
  localparam logic [12:0] FRAME_CNT_RESET = 13'h0000;
  localparam logic [12:0] FRAME_CNT_ONE = 13'h0001;

  // Host settle time after a manual update, in half receive clocks
  localparam int MCLK_PERIOD_NS = 25;
  localparam int HOST_WAIT_HALF_CLKS = 3;
  localparam int HOST_WAIT_CYCLES = (HOST_WAIT_HALF_CLKS + 1) / 2;

  typedef struct packed {
    logic e1_mode;
    logic t1_framing_mode_select;   // 1 = ESF, 0 = D4
    logic fs_error_report_enable;
    logic mos_or_fbit_select;       // 1 = multiframes out of sync
    logic short_interval_select;
    logic accumulation_mode_select; // 1 = manual update
    logic manual_update_trigger;
  } tpec_cfg_type;

  typedef struct packed {
    logic receive_sync_lost_flag;
    logic fas_lost;
    logic crc4_mf_lost;
    logic cas_mf_lost;
    logic crc4_mf_active;
  } tpec_sync_type;

  typedef struct packed {
    logic frame_pulse;
    logic crc6_err;
    logic ft_err;
    logic fs_err;
    logic fps_err;
    logic mf_out_of_sync;
    logic crc4_err;
    logic fas_word_err;
    logic ebit_strobe;
    logic ebit_value;
  } tpec_evt_type;

endpackage

// [verilog/tpec_interval_timer.sv]
// Frame-counting timer that marks the automatic update boundaries.
// Assumes frame_pulse is one cycle per received frame.
`timescale 1ns/1ps
module tpec_interval_timer #(
  parameter logic [12:0] SEC_FRAMES = tpec_pkg::ONE_SEC_FRAMES
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic frame_pulse,
  input wire logic e1_mode,
  input wire logic short_interval_select,
  output logic tick
);

  typedef struct packed {
    logic [12:0] frames;
    logic tick;
  } tpec_timer_state_type;

  tpec_timer_state_type st_reg;
  tpec_timer_state_type st_next;
  logic [12:0] target;

  always_comb begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (short_interval_select) begin
      target = e1_mode ? tpec_pkg::E1_SHORT_FRAMES
                       : tpec_pkg::T1_SHORT_FRAMES;
    end else begin
      target = SEC_FRAMES;
    end
    if (frame_pulse) begin
      // Wrap also when a mode change leaves the count past the target
      if (st_reg.frames + tpec_pkg::FRAME_CNT_ONE >= target) begin
        st_next.frames = tpec_pkg::FRAME_CNT_RESET;
        st_next.tick = 1'b1;
      end else begin
        st_next.frames = st_reg.frames + tpec_pkg::FRAME_CNT_ONE;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tick = st_reg.tick;

endmodule

// [test/tpec_tb.sv]
// Self-checking bench for the receive path error counters.
// Drives config, sync levels and framer strobes directly at the pins.
`timescale 1ns/1ps
module tb;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  tpec_pkg::tpec_cfg_type cfg;
  tpec_pkg::tpec_sync_type sync;
  tpec_pkg::tpec_evt_type evt;
  logic rd_en = 1'b0;
  logic [7:0] rd_addr = 8'h00;
  logic [7:0] rd_data;
  logic update_pulse;
  logic rd_pend = 1'b0;
  logic [7:0] exp_q[$];
  int failures = 0;
  int tests_run = 0;
  int upd_seen = 0;
  int n1, n2, n3, n4;
  tpec_pkg::tpec_evt_type e_crc6 = '{crc6_err:1'b1, default:1'b0};
  tpec_pkg::tpec_evt_type e_ft = '{ft_err:1'b1, default:1'b0};
  tpec_pkg::tpec_evt_type e_fs = '{fs_err:1'b1, default:1'b0};
  tpec_pkg::tpec_evt_type e_fps = '{fps_err:1'b1, default:1'b0};
  tpec_pkg::tpec_evt_type e_mos = '{mf_out_of_sync:1'b1, default:1'b0};
  tpec_pkg::tpec_evt_type e_crc4 = '{crc4_err:1'b1, default:1'b0};
  tpec_pkg::tpec_evt_type e_fas = '{fas_word_err:1'b1, default:1'b0};
  tpec_pkg::tpec_evt_type e_eb0 = '{ebit_strobe:1'b1, default:1'b0};
  tpec_pkg::tpec_evt_type e_eb1 = '{ebit_strobe:1'b1, ebit_value:1'b1,
                                    default:1'b0};
  tpec_pkg::tpec_evt_type e_all = '{crc4_err:1'b1, fas_word_err:1'b1,
                                    ebit_strobe:1'b1, default:1'b0};
  tpec_pkg::tpec_evt_type e_frm = '{frame_pulse:1'b1, default:1'b0};

  always #12.5 mclk = ~mclk;

  tpec_error_counters #(.SEC_FRAMES(13'h14)) dut (
    .mclk(mclk),
    .nrst(nrst),
    .cfg(cfg),
    .sync(sync),
    .evt(evt),
    .rd_en(rd_en),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .update_pulse(update_pulse)
  );

  task automatic end_sim();
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: read %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_cnt(input int got, input int exp);
    tests_run++;
    if (got != exp) begin
      failures++;
      $display("CHECK FAILED at %0t: updates %0d expected %0d", $time, got,
               exp);
    end
  endtask

  // Read result lands one edge after the read is taken
  always @(posedge mclk) rd_pend <= rd_en;
  always @(posedge mclk) if (update_pulse === 1'b1) upd_seen++;
  always @(negedge mclk) begin
    if (rd_pend) begin
      if (exp_q.size() == 0) begin
        failures++;
        $display("CHECK FAILED at %0t: unexpected read data", $time);
      end else begin
        cmp_byte(rd_data, exp_q.pop_front());
      end
    end
  end

  initial begin
    repeat (90000) @(posedge mclk);
    failures++;
    $display("CHECK FAILED at %0t: run did not finish", $time);
    end_sim();
  end

  // Back-to-back reads of a high and a low byte
  task automatic rd2(input logic [7:0] a, input logic [7:0] b,
                     input logic [15:0] e);
    rd_en = 1'b1;
    rd_addr = a;
    exp_q.push_back(e[15:8]);
    @(negedge mclk);
    rd_addr = b;
    exp_q.push_back(e[7:0]);
    @(negedge mclk);
    rd_en = 1'b0;
    @(negedge mclk);
  endtask

  task automatic check3(input logic [15:0] p, input logic [15:0] s,
                        input logic [15:0] f);
    rd2(tpec_pkg::PV_HIGH_ADDR, tpec_pkg::PV_LOW_ADDR, p);
    rd2(tpec_pkg::SYNC_HIGH_ADDR, tpec_pkg::SYNC_LOW_ADDR, s);
    rd2(tpec_pkg::FEBE_HIGH_ADDR, tpec_pkg::FEBE_LOW_ADDR, f);
  endtask

  task automatic ev(input tpec_pkg::tpec_evt_type e, input int n);
    repeat (n) begin
      evt = e;
      @(negedge mclk);
      evt = '0;
      @(negedge mclk);
    end
  endtask

  task automatic upd();
    int u0;
    u0 = upd_seen;
    cfg.manual_update_trigger = 1'b1;
    @(negedge mclk);
    cfg.manual_update_trigger = 1'b0;
    repeat (tpec_pkg::HOST_WAIT_CYCLES) @(negedge mclk);
    cmp_cnt(upd_seen - u0, 1);
  endtask

  task automatic do_reset();
    nrst = 1'b0;
    repeat (3) @(negedge mclk);
    nrst = 1'b1;
    @(negedge mclk);
    upd_seen = 0;
  endtask

  initial begin
    cfg = '{accumulation_mode_select:1'b1, t1_framing_mode_select:1'b1,
            default:1'b0};
    sync = '{crc4_mf_active:1'b1, default:1'b0};
    evt = '0;
    n1 = $urandom(31574);
    do_reset();
    check3(16'h0000, 16'h0000, 16'h0000);
    rd2(8'h43, 8'h4A, 16'h0000);
    // T1 ESF with framing bit error selection
    n1 = $urandom_range(9, 1);
    n2 = $urandom_range(9, 1);
    ev(e_crc6, n1);
    sync.receive_sync_lost_flag = 1'b1;
    ev(e_crc6, 2);
    ev(e_fps, 1);
    sync.receive_sync_lost_flag = 1'b0;
    ev(e_fps, n2);
    ev(e_ft, 1);
    ev(e_eb0, 3);
    upd();
    check3(16'(n1), 16'(n2), 16'h0000);
    // T1 D4
    cfg.t1_framing_mode_select = 1'b0;
    n3 = $urandom_range(9, 1);
    n4 = $urandom_range(9, 1);
    ev(e_ft, n3);
    ev(e_fs, 1);
    ev(e_crc6, 1);
    cfg.fs_error_report_enable = 1'b1;
    ev(e_fs, n4);
    upd();
    check3(16'(n3 + n4), 16'(n3), 16'h0000);
    // Multiframes out of sync, counted while sync is lost
    cfg.mos_or_fbit_select = 1'b1;
    sync.receive_sync_lost_flag = 1'b1;
    ev(e_mos, n1);
    ev(e_ft, 1);
    sync.receive_sync_lost_flag = 1'b0;
    upd();
    check3(16'h0000, 16'(n1), 16'h0000);
    // E1
    cfg.e1_mode = 1'b1;
    ev(e_crc4, n2);
    ev(e_fas, n3);
    ev(e_eb0, n4);
    ev(e_eb1, 2);
    sync.cas_mf_lost = 1'b1;
    ev(e_all, 1);
    sync.cas_mf_lost = 1'b0;
    sync.fas_lost = 1'b1;
    ev(e_all, 1);
    sync.fas_lost = 1'b0;
    sync.crc4_mf_lost = 1'b1;
    ev(e_all, 1);
    sync.crc4_mf_lost = 1'b0;
    sync.receive_sync_lost_flag = 1'b1;
    ev(e_fas, 1);
    sync = '{default:1'b0};
    ev(e_eb0, 1);
    sync.crc4_mf_active = 1'b1;
    upd();
    check3(16'(n2 + 1), 16'(n3), 16'(n4 + 1));
    // Saturation of the path count
    cfg = '{accumulation_mode_select:1'b1, t1_framing_mode_select:1'b1,
            default:1'b0};
    evt = e_crc6;
    repeat (65540) @(negedge mclk);
    evt = '0;
    upd();
    check3(16'hFFFF, 16'h0000, 16'h0000);
    upd();
    check3(16'h0000, 16'h0000, 16'h0000);
    // Timer driven updates
    do_reset();
    cfg.accumulation_mode_select = 1'b0;
    ev(e_crc6, 3);
    ev(e_frm, 19);
    cmp_cnt(upd_seen, 0);
    check3(16'h0000, 16'h0000, 16'h0000);
    ev(e_frm, 1);
    cmp_cnt(upd_seen, 1);
    check3(16'h0003, 16'h0000, 16'h0000);
    cfg.short_interval_select = 1'b1;
    ev(e_frm, 332);
    cmp_cnt(upd_seen, 1);
    ev(e_frm, 1);
    cmp_cnt(upd_seen, 2);
    cfg.e1_mode = 1'b1;
    ev(e_frm, 499);
    cmp_cnt(upd_seen, 2);
    ev(e_frm, 1);
    cmp_cnt(upd_seen, 3);
    cfg.manual_update_trigger = 1'b1;
    @(negedge mclk);
    cfg.manual_update_trigger = 1'b0;
    repeat (2) @(negedge mclk);
    cmp_cnt(upd_seen, 3);
    if (exp_q.size() != 0) begin
      failures++;
      $display("CHECK FAILED at %0t: reads left unanswered", $time);
    end
    end_sim();
  end
endmodule
